// file: hw/system_control_ext_irq.sv
`timescale 1ns/1ps
module system_control_ext_irq (
  input wire logic clk,
  input wire logic rst,
  input wire logic [sysctl_pkg::ADDR_W-1:0] addr,
  input wire logic [sysctl_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [sysctl_pkg::DATA_W-1:0] rd_data,
  input wire logic periph_illegal_access,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic watchdog_timeout,
  output logic cpu_reset,
  output logic nmi_req,
  input wire logic cpu_clock_in,
  input wire logic watchdog_tick_clock,
  output logic cpu_clock_output,
  output logic clock_pin_source_select,
  output logic [1:0] low_power_select,
  input wire logic idle_exec,
  input wire logic periph_wake,
  output sysctl_pkg::lp_state_t low_power_state,
  input wire logic ext_irq_pin_one,
  input wire logic ext_irq_pin_two,
  input wire logic [1:0] ext_irq_ack,
  output logic [1:0] ext_irq_req,
  output logic [1:0] ext_irq_low_prio,
  output logic ext_wake,
  output logic irq
);
  import sysctl_pkg::*;

  // ==========================================================
  // Storage
  logic illegal_access_flag_reg;
  logic clk_src_reg;
  logic [1:0] lps_reg;
  logic [1:0] ext_pol_reg;
  logic [1:0] ext_prio_reg;
  logic [1:0] ext_en_reg;
  logic [1:0] ext_flag_reg;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] prev_reg;
  logic [EVT_W-1:0] evt_status_reg;
  logic [EVT_W-1:0] evt_enable_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic cpu_reset_reg;
  logic reset_pin_oe_reg;
  logic nmi_reg;
  logic clk_pin_reg;
  logic [1:0] ext_req_reg;
  logic ext_wake_reg;
  logic irq_reg;
  lp_state_t lp_state_reg;
  lp_state_t lp_state_next;

  logic [1:0] edge_det;
  logic illegal_hit;
  logic [EVT_W-1:0] evt_set;
  logic [1:0] flag_wr_clear;

  // ==========================================================
  // Helpers
  // Address is one of ours
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == SYS_CTRL_ADDR) || (a == DEV_ID_ADDR) ||
                (a == EXT_ONE_ADDR) || (a == EXT_TWO_ADDR) ||
                (a == EVT_STATUS_ADDR) || (a == EVT_ENABLE_ADDR) ||
                (a == EVT_CLEAR_ADDR);
  endfunction

  // Edge of the chosen polarity on a synchronised pin
  function automatic logic edge_of(input logic cur, input logic old, input logic rising);
    edge_of = rising ? (cur & ~old) : (~cur & old);
  endfunction

  // Compose an interrupt control word; reserved bits stay zero
  function automatic logic [DATA_W-1:0] ext_word(input logic f, input logic p,
                                                 input logic pr, input logic e);
    ext_word = '0;
    ext_word[EXT_FLAG_BIT] = f;
    ext_word[EXT_POL_BIT] = p;
    ext_word[EXT_PRIO_BIT] = pr;
    ext_word[EXT_EN_BIT] = e;
  endfunction

  // ==========================================================
  // Decode
  // Unmapped access, or one flagged by another peripheral decoder
  assign illegal_hit = ((wr_strobe || rd_strobe) && !is_mapped(addr)) ||
                       periph_illegal_access;
  assign flag_wr_clear[0] = wr_strobe && (addr == EXT_ONE_ADDR) && wr_data[EXT_FLAG_BIT];
  assign flag_wr_clear[1] = wr_strobe && (addr == EXT_TWO_ADDR) && wr_data[EXT_FLAG_BIT];

  // ==========================================================
  // Reset merge and reset pin
  // Reset pin input also sees our own low drive, so the core stays held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_reset_reg <= 1'b1;
      reset_pin_oe_reg <= 1'b0;
    end else begin
      cpu_reset_reg <= reset_pin_in | watchdog_timeout;
      reset_pin_oe_reg <= watchdog_timeout;
    end
  end

  // ==========================================================
  // Illegal-access flag
  // No reset on purpose: the flag survives a device reset
  always_ff @(posedge clk) begin
    if (illegal_hit) begin
      illegal_access_flag_reg <= 1'b1;
    end else if (wr_strobe && (addr == SYS_CTRL_ADDR) && wr_data[ILLEGAL_BIT]) begin
      illegal_access_flag_reg <= 1'b0;
    end
  end

  // One-cycle NMI per illegal access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi_reg <= 1'b0;
    end else begin
      nmi_reg <= illegal_hit;
    end
  end

  // ==========================================================
  // System control fields
  // Reserved bits are not stored, so they read back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_src_reg <= CLK_SRC_RST;
      lps_reg <= LPS_RST;
    end else if (wr_strobe && (addr == SYS_CTRL_ADDR)) begin
      clk_src_reg <= wr_data[CLK_SRC_BIT];
      lps_reg <= wr_data[LPS_HI_BIT:LPS_LO_BIT];
    end
  end

  // Clock pin: both sources sampled, so the pin runs at most half of clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_pin_reg <= 1'b0;
    end else begin
      clk_pin_reg <= clk_src_reg ? watchdog_tick_clock : cpu_clock_in;
    end
  end

  // ==========================================================
  // External interrupt pins
  // Two-stage synchroniser, then an edge detector on the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else begin
      sync1_reg <= {ext_irq_pin_two, ext_irq_pin_one};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign edge_det[0] = edge_of(sync2_reg[0], prev_reg[0], ext_pol_reg[0]);
  assign edge_det[1] = edge_of(sync2_reg[1], prev_reg[1], ext_pol_reg[1]);

  // Control bits; bits 14-3 are never stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_pol_reg <= EXT_CTRL_RST;
      ext_prio_reg <= EXT_CTRL_RST;
      ext_en_reg <= EXT_CTRL_RST;
    end else if (wr_strobe) begin
      for (int i = 0; i < 2; i++) begin
        if (addr == (i == 0 ? EXT_ONE_ADDR : EXT_TWO_ADDR)) begin
          ext_pol_reg[i] <= wr_data[EXT_POL_BIT];
          ext_prio_reg[i] <= wr_data[EXT_PRIO_BIT];
          ext_en_reg[i] <= wr_data[EXT_EN_BIT];
        end
      end
    end
  end

  // Flags: a fresh edge beats acknowledge and clearing write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_flag_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (edge_det[i]) begin
          ext_flag_reg[i] <= 1'b1;
        end else if (ext_irq_ack[i] || flag_wr_clear[i]) begin
          ext_flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Requests toward the expansion controller
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_req_reg <= 2'h0;
    end else begin
      ext_req_reg <= ext_flag_reg & ext_en_reg;
    end
  end

  // ==========================================================
  // Low-power state
  // Halt leaves only through reset, since its clocks are gone
  always_comb begin
    lp_state_next = lp_state_reg;
    unique case (lp_state_reg)
      LP_RUN: begin
        if (idle_exec) begin
          if (lps_reg[1]) begin
            lp_state_next = LP_HALT;
          end else if (lps_reg == LPS_DEEP) begin
            lp_state_next = LP_DEEP;
          end else begin
            lp_state_next = LP_LIGHT;
          end
        end
      end
      LP_LIGHT: begin
        if ((|edge_det) || periph_wake) begin
          lp_state_next = LP_RUN;
        end
      end
      LP_DEEP: begin
        if (|edge_det) begin
          lp_state_next = LP_RUN;
        end
      end
      LP_HALT: begin
        lp_state_next = LP_HALT;
      end
    endcase
    if (cpu_reset_reg) begin
      lp_state_next = LP_RUN;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lp_state_reg <= LP_RUN;
      ext_wake_reg <= 1'b0;
    end else begin
      lp_state_reg <= lp_state_next;
      ext_wake_reg <= (|edge_det) && ((lp_state_reg == LP_LIGHT) ||
                                      (lp_state_reg == LP_DEEP));
    end
  end

  // ==========================================================
  // Event status, enable and interrupt line
  assign evt_set = {watchdog_timeout & ~reset_pin_oe_reg, edge_det[1], edge_det[0],
                    illegal_hit};

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_status_reg <= EVT_RST;
      evt_enable_reg <= EVT_RST;
    end else begin
      if (wr_strobe && (addr == EVT_CLEAR_ADDR)) begin
        evt_status_reg <= (evt_status_reg & ~wr_data[EVT_W-1:0]) | evt_set;
      end else begin
        evt_status_reg <= evt_status_reg | evt_set;
      end
      if (wr_strobe && (addr == EVT_ENABLE_ADDR)) begin
        evt_enable_reg <= wr_data[EVT_W-1:0];
      end
    end
  end

  // Level line, one cycle behind the status bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(evt_status_reg & evt_enable_reg);
    end
  end

  // ==========================================================
  // Read path, data valid only the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= '0;
      if (rd_strobe) begin
        unique case (addr)
          SYS_CTRL_ADDR: begin
            rd_data_reg[CLK_SRC_BIT] <= clk_src_reg;
            rd_data_reg[LPS_HI_BIT:LPS_LO_BIT] <= lps_reg;
            rd_data_reg[ILLEGAL_BIT] <= illegal_access_flag_reg;
          end
          DEV_ID_ADDR: rd_data_reg <= {DEVICE_ID, REVISION};
          EXT_ONE_ADDR: rd_data_reg <= ext_word(ext_flag_reg[0], ext_pol_reg[0],
                                                ext_prio_reg[0], ext_en_reg[0]);
          EXT_TWO_ADDR: rd_data_reg <= ext_word(ext_flag_reg[1], ext_pol_reg[1],
                                                ext_prio_reg[1], ext_en_reg[1]);
          EVT_STATUS_ADDR: rd_data_reg[EVT_W-1:0] <= evt_status_reg;
          EVT_ENABLE_ADDR: rd_data_reg[EVT_W-1:0] <= evt_enable_reg;
          default: rd_data_reg <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Outputs
  assign rd_data = rd_data_reg;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = reset_pin_oe_reg;
  assign cpu_reset = cpu_reset_reg;
  assign nmi_req = nmi_reg;
  assign cpu_clock_output = clk_pin_reg;
  assign clock_pin_source_select = clk_src_reg;
  assign low_power_select = lps_reg;
  assign low_power_state = lp_state_reg;
  assign ext_irq_req = ext_req_reg;
  assign ext_irq_low_prio = ext_prio_reg;
  assign ext_wake = ext_wake_reg;
  assign irq = irq_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // The first edge after a release still shows the reset value, so skip it
  core_reset_merge_a: assert property (
    !$past(rst) |-> cpu_reset_reg == $past(reset_pin_in | watchdog_timeout))
    else $error("core reset not the OR of pin and watchdog");
  reset_pin_drive_a: assert property (
    watchdog_timeout |=> reset_pin_oe && !reset_pin_out)
    else $error("reset pin not driven low on watchdog timeout");
  illegal_flag_set_a: assert property (
    illegal_hit |=> illegal_access_flag_reg ##1 1'b1)
    else $error("illegal access did not set the flag");
  illegal_nmi_a: assert property (
    illegal_hit |=> nmi_req)
    else $error("no nmi after illegal access");
  illegal_flag_hold_a: assert property (
    illegal_access_flag_reg && !(wr_strobe && addr == SYS_CTRL_ADDR && wr_data[ILLEGAL_BIT])
    |=> illegal_access_flag_reg)
    else $error("illegal flag dropped without a clear");
  illegal_flag_clear_a: assert property (
    wr_strobe && addr == SYS_CTRL_ADDR && wr_data[ILLEGAL_BIT] && !periph_illegal_access
    |=> !illegal_access_flag_reg)
    else $error("writing one did not clear the illegal flag");
  clock_pin_route_a: assert property (
    !$past(rst) |-> cpu_clock_output == $past(clk_src_reg ? watchdog_tick_clock : cpu_clock_in))
    else $error("clock pin carries the wrong source");
  deep_idle_entry_a: assert property (
    lp_state_reg == LP_RUN && idle_exec && lps_reg == LPS_DEEP && !cpu_reset_reg
    |=> low_power_state == LP_DEEP)
    else $error("deep idle not entered");
  reserved_zero_a: assert property (
    rd_strobe && addr == SYS_CTRL_ADDR |=> rd_data[15] == 1'b0 && rd_data[11:1] == 11'h000)
    else $error("reserved control bits not zero");
  id_read_a: assert property (
    rd_strobe && addr == DEV_ID_ADDR |=> rd_data == {DEVICE_ID, REVISION})
    else $error("identification read wrong");
  edge_sets_flag_a: assert property (
    $rose(sync2_reg[0]) && ext_pol_reg[0] |=> ext_flag_reg[0])
    else $error("rising edge did not set flag one");
  ack_clears_flag_a: assert property (
    ext_irq_ack[1] && !edge_det[1] |=> !ext_flag_reg[1])
    else $error("acknowledge did not clear flag two");
  halt_sticks_a: assert property (
    lp_state_reg == LP_HALT && !cpu_reset_reg |=> low_power_state == LP_HALT)
    else $error("halt left without reset");
  request_gate_a: assert property (
    ##1 ext_irq_req == $past(ext_flag_reg & ext_en_reg))
    else $error("request not flag and enable");
  set_beats_clear_a: assert property (
    edge_det[0] && flag_wr_clear[0] |=> ext_flag_reg[0])
    else $error("clear beat a new event");

  illegal_seen_c: cover property (illegal_hit ##1 nmi_req);
  ext_req_c: cover property (edge_det[0] ##[1:3] ext_irq_req[0]);
  deep_wake_c: cover property (lp_state_reg == LP_DEEP ##1 lp_state_reg == LP_RUN);
  halt_entry_c: cover property (lp_state_reg == LP_HALT);

endmodule

// file: hw/sysctl_pkg.sv
package sysctl_pkg;

  // ==========================================================
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // ==========================================================
  // Register addresses (word addresses on the plain port)
  localparam logic [15:0] SYS_CTRL_ADDR = 16'h7018;
  localparam logic [15:0] DEV_ID_ADDR = 16'h701C;
  localparam logic [15:0] EXT_ONE_ADDR = 16'h7070;
  localparam logic [15:0] EXT_TWO_ADDR = 16'h7071;
  localparam logic [15:0] EVT_STATUS_ADDR = 16'h7020;
  localparam logic [15:0] EVT_ENABLE_ADDR = 16'h7021;
  localparam logic [15:0] EVT_CLEAR_ADDR = 16'h7022;

  // ==========================================================
  // System control fields
  localparam int ILLEGAL_BIT = 0;
  localparam int LPS_LO_BIT = 12;
  localparam int LPS_HI_BIT = 13;
  localparam int CLK_SRC_BIT = 14;
  localparam logic CLK_SRC_RST = 1'h0;
  localparam logic [1:0] LPS_RST = 2'h0;
  localparam logic [1:0] LPS_LIGHT = 2'h0;
  localparam logic [1:0] LPS_DEEP = 2'h1;

  // ==========================================================
  // Identification fields, values arbitrary
  localparam logic [11:0] DEVICE_ID = 12'h5A5;
  localparam logic [3:0] REVISION = 4'h1;

  // ==========================================================
  // External interrupt control fields
  localparam int EXT_EN_BIT = 0;
  localparam int EXT_PRIO_BIT = 1;
  localparam int EXT_POL_BIT = 2;
  localparam int EXT_FLAG_BIT = 15;
  localparam logic [1:0] EXT_CTRL_RST = 2'h0;

  // ==========================================================
  // Event status bits
  localparam int EVT_W = 4;
  localparam int EVT_ILLEGAL = 0;
  localparam int EVT_EXT_ONE = 1;
  localparam int EVT_EXT_TWO = 2;
  localparam int EVT_WATCHDOG = 3;
  localparam logic [3:0] EVT_RST = 4'h0;

  // ==========================================================
  // Low-power state, Gray along run-light-deep-halt
  typedef enum logic [1:0] {
    LP_RUN = 2'h0,
    LP_LIGHT = 2'h1,
    LP_DEEP = 2'h3,
    LP_HALT = 2'h2
  } lp_state_t;

endpackage

// file: dv/irq_ack_model.sv
`timescale 1ns/1ps
// ==========================================
// Expansion controller side: answers requests
module irq_ack_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic ack_on,
  input wire logic slow,
  input wire logic [1:0] ext_irq_req,
  output logic [1:0] ext_irq_ack
);
  logic [3:0] cnt_reg [2];

  // Ack after a delay; the tail of the count keeps a falling request
  // from being taken twice
  always_ff @(posedge clk or posedge rst) begin
    for (int i = 0; i < 2; i++) begin
      if (rst) begin
        cnt_reg[i] <= 4'h0;
        ext_irq_ack[i] <= 1'b0;
      end else begin
        ext_irq_ack[i] <= (cnt_reg[i] == 4'h3) && ext_irq_req[i];
        if (cnt_reg[i] != 4'h0) begin
          cnt_reg[i] <= cnt_reg[i] - 4'h1;
        end else if (ext_irq_req[i] && ack_on) begin
          cnt_reg[i] <= slow ? 4'hc : 4'h4;
        end
      end
    end
  end
endmodule

// file: dv/test_system_control_ext_irq.sv
`timescale 1ns/1ps
module test_system_control_ext_irq;
  import sysctl_pkg::*;
  typedef struct {logic [15:0] a; logic [15:0] w; logic [15:0] e;} row_t;
  logic clk, rst, wr_strobe, rd_strobe, periph_illegal_access, reset_pin_in;
  logic reset_pin_out, reset_pin_oe, watchdog_timeout, cpu_reset, nmi_req;
  logic cpu_clock_in, watchdog_tick_clock, cpu_clock_output, clock_pin_source_select;
  logic idle_exec, periph_wake, ext_irq_pin_one, ext_irq_pin_two, ext_wake, irq;
  logic ack_on, slow, nmi_seen;
  logic [15:0] addr, wr_data, rd_data, got;
  logic [1:0] low_power_select, ext_irq_ack, ext_irq_req, ext_irq_low_prio;
  lp_state_t low_power_state;
  lp_state_t lp_exp [3];
  row_t rows [8];
  int failures, n_tests, cycles, n_wake;

  system_control_ext_irq i_dut (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .periph_illegal_access(periph_illegal_access),
    .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .watchdog_timeout(watchdog_timeout), .cpu_reset(cpu_reset), .nmi_req(nmi_req),
    .cpu_clock_in(cpu_clock_in), .watchdog_tick_clock(watchdog_tick_clock),
    .cpu_clock_output(cpu_clock_output), .clock_pin_source_select(clock_pin_source_select),
    .low_power_select(low_power_select), .idle_exec(idle_exec), .periph_wake(periph_wake),
    .low_power_state(low_power_state), .ext_irq_pin_one(ext_irq_pin_one),
    .ext_irq_pin_two(ext_irq_pin_two), .ext_irq_ack(ext_irq_ack), .ext_irq_req(ext_irq_req),
    .ext_irq_low_prio(ext_irq_low_prio), .ext_wake(ext_wake), .irq(irq));

  irq_ack_model i_peer (
    .clk(clk), .rst(rst), .ack_on(ack_on), .slow(slow), .ext_irq_req(ext_irq_req),
    .ext_irq_ack(ext_irq_ack));

  // ==========================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Wake pulses counted where they have settled
  always @(negedge clk) begin
    if (ext_wake === 1'b1) begin
      n_wake++;
    end
  end

  // Whole run needs about 300 cycles; ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask

  // Read data and the nmi pulse both stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    got = rd_data;
    nmi_seen = nmi_req;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    rd(a);
    chk(got, e);
  endtask

  // Bounded wait for a channel request
  task automatic wait_req(input int ch);
    for (int k = 0; k < 10 && ext_irq_req[ch] !== 1'b1; k++) tick(1);
    chk(16'(ext_irq_req[ch]), 16'h0001);
  endtask

  // Pin two low then high, two sync stages plus margin each way
  task automatic edge_two();
    @(posedge clk) ext_irq_pin_two <= 1'b0;
    tick(4);
    @(posedge clk) ext_irq_pin_two <= 1'b1;
    tick(6);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {rst, wr_strobe, rd_strobe, periph_illegal_access, reset_pin_in} = 5'h10;
    {watchdog_timeout, cpu_clock_in, watchdog_tick_clock, idle_exec} = 4'h0;
    {periph_wake, ext_irq_pin_one, ext_irq_pin_two, ack_on, slow} = 5'h00;
    addr = 16'h0000;
    wr_data = 16'h0000;
    lp_exp = '{LP_LIGHT, LP_DEEP, LP_HALT};
    rows = '{'{SYS_CTRL_ADDR, 16'hffff, 16'h7000}, '{SYS_CTRL_ADDR, 16'h2000, 16'h2000},
      '{SYS_CTRL_ADDR, 16'h0000, 16'h0000}, '{DEV_ID_ADDR, 16'hffff, {DEVICE_ID, REVISION}},
      '{EXT_ONE_ADDR, 16'hffff, 16'h0007}, '{EXT_TWO_ADDR, 16'h7ffa, 16'h0002},
      '{EXT_ONE_ADDR, 16'h0000, 16'h0000}, '{EXT_TWO_ADDR, 16'h0000, 16'h0000}};
    tick(11);
    chk(16'(cpu_reset), 16'h0001);
    @(posedge clk) rst <= 1'b0;
    rd_chk(EXT_ONE_ADDR, 16'h0000);
    rd(SYS_CTRL_ADDR);
    chk(got & 16'h7ffe, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].e);
    end
    // Illegal access: flag, nmi, stickiness, write-one clear
    rd(16'h7019);
    chk(got, 16'h0000);
    chk(16'(nmi_seen), 16'h0001);
    rd_chk(DEV_ID_ADDR, {DEVICE_ID, REVISION});
    rd_chk(SYS_CTRL_ADDR, 16'h0001);
    wr(SYS_CTRL_ADDR, 16'h0000);
    rd_chk(SYS_CTRL_ADDR, 16'h0001);
    wr(SYS_CTRL_ADDR, 16'h0001);
    rd_chk(SYS_CTRL_ADDR, 16'h0000);
    // Event interrupt raised, cleared, then masked
    wr(EVT_ENABLE_ADDR, 16'h0001);
    @(posedge clk) periph_illegal_access <= 1'b1;
    @(posedge clk) periph_illegal_access <= 1'b0;
    tick(3);
    chk(16'(irq), 16'h0001);
    wr(EVT_CLEAR_ADDR, 16'h000f);
    tick(2);
    chk(16'(irq), 16'h0000);
    wr(EVT_ENABLE_ADDR, 16'h0000);
    rd(16'h7072);
    tick(3);
    chk(16'(irq), 16'h0000);
    rd_chk(EVT_STATUS_ADDR, 16'h0001);
    rd_chk(SYS_CTRL_ADDR, 16'h0001);
    // Clock pin source
    @(posedge clk) cpu_clock_in <= 1'b1;
    wr(SYS_CTRL_ADDR, 16'h4001);
    tick(3);
    chk(16'(cpu_clock_output), 16'h0000);
    chk(16'(clock_pin_source_select), 16'h0001);
    wr(SYS_CTRL_ADDR, 16'h0000);
    tick(3);
    chk(16'(cpu_clock_output), 16'h0001);
    chk(16'(clock_pin_source_select), 16'h0000);
    // External interrupt one, no acknowledge
    wr(EXT_ONE_ADDR, 16'h0007);
    tick(2);
    chk(16'(ext_irq_low_prio), 16'h0001);
    wr(EXT_ONE_ADDR, 16'h0005);
    @(posedge clk) ext_irq_pin_one <= 1'b1;
    wait_req(0);
    rd_chk(EXT_ONE_ADDR, 16'h8005);
    chk(16'(ext_irq_low_prio), 16'h0000);
    wr(EXT_ONE_ADDR, 16'h0005);
    rd_chk(EXT_ONE_ADDR, 16'h8005);
    wr(EXT_ONE_ADDR, 16'h8005);
    rd_chk(EXT_ONE_ADDR, 16'h0005);
    chk(16'(ext_irq_req[0]), 16'h0000);
    @(posedge clk) ext_irq_pin_one <= 1'b0;
    tick(6);
    rd_chk(EXT_ONE_ADDR, 16'h0005);
    wr(EXT_ONE_ADDR, 16'h0004);
    @(posedge clk) ext_irq_pin_one <= 1'b1;
    tick(6);
    rd_chk(EXT_ONE_ADDR, 16'h8004);
    chk(16'(ext_irq_req[0]), 16'h0000);
    // Clearing write lands on the very edge that sets the flag again
    @(posedge clk) ext_irq_pin_one <= 1'b0;
    tick(4);
    @(posedge clk) ext_irq_pin_one <= 1'b1;
    @(posedge clk);
    wr(EXT_ONE_ADDR, 16'h8004);
    rd_chk(EXT_ONE_ADDR, 16'h8004);
    // Acknowledge from the peer, prompt then slow on channel two
    @(posedge clk) ack_on <= 1'b1;
    wr(EXT_ONE_ADDR, 16'h0005);
    tick(12);
    rd_chk(EXT_ONE_ADDR, 16'h0005);
    @(posedge clk) slow <= 1'b1;
    @(posedge clk) ext_irq_pin_two <= 1'b1;
    tick(6);
    wr(EXT_TWO_ADDR, 16'h0001);
    @(posedge clk) ext_irq_pin_two <= 1'b0;
    wait_req(1);
    tick(20);
    rd_chk(EXT_TWO_ADDR, 16'h0001);
    // Idle modes and wake by edge; halt ends only by reset
    wr(EXT_TWO_ADDR, 16'h0004);
    for (int m = 0; m < 3; m++) begin
      wr(SYS_CTRL_ADDR, 16'(m) << 12);
      @(posedge clk) idle_exec <= 1'b1;
      @(posedge clk) idle_exec <= 1'b0;
      tick(1);
      chk(16'(low_power_state), 16'(lp_exp[m]));
      chk(16'(low_power_select), 16'(m));
      edge_two();
      chk(16'(low_power_state), 16'(m == 2 ? LP_HALT : LP_RUN));
    end
    chk(16'(n_wake), 16'h0002);
    @(posedge clk) reset_pin_in <= 1'b1;
    tick(2);
    chk(16'(cpu_reset), 16'h0001);
    chk(16'(reset_pin_oe), 16'h0000);
    @(posedge clk) reset_pin_in <= 1'b0;
    tick(2);
    chk(16'(low_power_state), 16'(LP_RUN));
    // Watchdog self-reset drives the pin low
    @(posedge clk) watchdog_timeout <= 1'b1;
    tick(2);
    chk(16'(cpu_reset), 16'h0001);
    chk({15'h0, reset_pin_oe}, {15'h0, ~reset_pin_out});
    chk(16'(reset_pin_oe), 16'h0001);
    @(posedge clk) watchdog_timeout <= 1'b0;
    tick(3);
    chk(16'(reset_pin_oe), 16'h0000);
    // Second reset: flag of channel two goes, illegal flag stays
    rd(16'h7019);
    @(posedge clk) rst <= 1'b1;
    tick(2);
    @(posedge clk) rst <= 1'b0;
    rd_chk(EXT_TWO_ADDR, 16'h0000);
    rd_chk(SYS_CTRL_ADDR, 16'h0001);
    tally_and_finish();
  end
endmodule
